// ==== rtl/rpsel_map_store.sv ====
module rpsel_map_store (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire rpsel_pkg::rpsel_wr_s wr_i,
   input wire logic [4:0] rd_idx_i,
   output logic [15:0] rd_data_o,
   output rpsel_pkg::rpsel_map_t map_o,
   output logic mismatch_o
);
   import rpsel_pkg::*;

   rpsel_map_t live_ff;
   rpsel_map_t shadow_ff;
   logic [15:0] rd_ff;
   logic mismatch_ff;

   // Live and shadow take every legal write together
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         live_ff <= {RPSEL_MAP_REGS{RPSEL_MAP_RST}}; // R10
         shadow_ff <= {RPSEL_MAP_REGS{RPSEL_MAP_RST}}; // R7
      end else if (ce_i && wr_i.en) begin
         live_ff[wr_i.idx] <= wr_i.data;
         shadow_ff[wr_i.idx] <= wr_i.data; // R7
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_ff <= RPSEL_MAP_RST;
      end else if (ce_i) begin
         rd_ff <= (rd_idx_i < 5'(RPSEL_MAP_REGS)) ? live_ff[rd_idx_i] : RPSEL_MAP_RST;
      end
   end

   // Only a disturbed cell can differ; hardware writes both copies at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mismatch_ff <= 1'b0;
      end else if (ce_i) begin
         mismatch_ff <= (live_ff != shadow_ff); // R7
      end
   end

   assign rd_data_o = rd_ff;
   assign map_o = live_ff;
   assign mismatch_o = mismatch_ff;
endmodule

// ==== rtl/rpsel_pkg.sv ====
// Function
// R1: Any combination of mapping register values is accepted, no cross interlock.
// R2: One pin may feed many inputs; one output may drive many pins.
// R3: Locked mapping writes are acknowledged normally but change nothing.
// R4: Write lock sits at bit 6 of oscillator control; one blocks, zero permits.
// R5: Lock bit changes only after keys 0x46 then 0x57 to control low byte.
// R6: Lock bit holds its value until changed through the key sequence.
// R7: Shadow copies compare continuously with live registers; mismatch raises device reset.
// R8: With the one-shot fuse active, a set lock bit cannot be cleared.
// R9: Fuse active when unprogrammed (high); inactive allows unlimited lock sessions.
// R10: Mapping registers reset to 0000h: inputs select pin zero, outputs disconnected.
// R11: Lock bit resets unlocked, so mapping writes work straight after reset.
// R12: Mapping never changes pin direction; mapped output may feed sharing inputs.
// R13: Mapping a peripheral does not enable it.
// R14: Remapped functions never override analog pins nor switch them to digital.
// R15: Software should point unused inputs at unused pins, unused pins at null.
// R16: Input register 0 bits 12-8 route pin n for n up to 01111; 11111 grounds.
// R17: Input register 0 bits 15-13 and 7-0 read zero, ignore writes.
// R18: Seventeen mapping registers, nine input and eight output, all lock protected.
// R19: Each input field is 5 bits and routes the pin numbered by its value.
// R20: Output field 00000 leaves default port function, 00011 uart tx, 00100 rts.
// R21: Active remapped output beats other digital functions but never analog ones.
// R22: Keys and lock change are consecutive writes; any other write aborts.
package rpsel_pkg;
   localparam int RPSEL_PINS = 16;
   localparam int RPSEL_IN_REGS = 9;
   localparam int RPSEL_OUT_REGS = 8;
   localparam int RPSEL_MAP_REGS = 17;
   localparam int RPSEL_IN_LANES = 17;
   localparam int RPSEL_CODES = 32;
   localparam int RPSEL_FLD_HI = 8;
   localparam int RPSEL_FLD_LO = 0;
   localparam int RPSEL_LOCK_POS = 6;
   localparam int RPSEL_STAT_LOCK = 0;
   localparam int RPSEL_STAT_FUSE = 1;
   localparam int RPSEL_STAT_KEY = 2;
   localparam logic [4:0] RPSEL_IDX_OUT_BASE = 5'h09;
   localparam logic [4:0] RPSEL_IDX_OSC = 5'h18;
   localparam logic [4:0] RPSEL_IDX_STAT = 5'h19;
   localparam logic [15:0] RPSEL_MAP_RST = 16'h0000;
   localparam logic [15:0] RPSEL_REG0_MASK = 16'h1f00;
   localparam logic [15:0] RPSEL_MAP_MASK = 16'h1f1f;
   localparam logic [7:0] RPSEL_KEY1 = 8'h46;
   localparam logic [7:0] RPSEL_KEY2 = 8'h57;
   localparam logic [4:0] RPSEL_SEL_GND = 5'h1f;
   localparam logic [4:0] RPSEL_OUT_NULL = 5'h00;
   localparam logic [4:0] RPSEL_OUT_UART1_TX = 5'h03;
   localparam logic [4:0] RPSEL_OUT_UART1_RTS = 5'h04;

   typedef enum logic [2:0] {
      RPSEL_KEY_IDLE = 3'b001,
      RPSEL_KEY_ONE = 3'b010,
      RPSEL_KEY_TWO = 3'b100
   } rpsel_key_e;

   typedef struct packed {
      logic en;
      logic [4:0] idx;
      logic [15:0] data;
   } rpsel_wr_s;

   typedef logic [RPSEL_MAP_REGS-1:0][15:0] rpsel_map_t;

   // Writable bits of a mapping register
   function automatic logic [15:0] rpsel_mask(input logic [4:0] idx);
      rpsel_mask = (idx == 5'h00) ? RPSEL_REG0_MASK : RPSEL_MAP_MASK;
   endfunction
endpackage

// ==== rtl/rpsel_sync2.sv ====
module rpsel_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   input wire logic [W-1:0] rst_val_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // Reset value comes in as a constant tie-off from the parent
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= rst_val_i;
         sync_ff <= rst_val_i;
      end else if (ce_i) begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule

// ==== rtl/rpsel_top.sv ====
module rpsel_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Configuration fuse, high when unprogrammed
   input wire logic one_shot_lock_fuse_i,
   // Pins and pin configuration
   input wire logic [rpsel_pkg::RPSEL_PINS-1:0] remap_pin_in_i,
   input wire logic [rpsel_pkg::RPSEL_PINS-1:0] analog_sel_i,
   input wire logic [rpsel_pkg::RPSEL_PINS-1:0] port_out_i,
   input wire logic [rpsel_pkg::RPSEL_PINS-1:0] port_oe_i,
   output logic [rpsel_pkg::RPSEL_PINS-1:0] remap_pin_out_o,
   output logic [rpsel_pkg::RPSEL_PINS-1:0] remap_pin_oe_o,
   // Peripheral side
   input wire logic [rpsel_pkg::RPSEL_CODES-1:0] periph_out_i,
   output logic [rpsel_pkg::RPSEL_IN_LANES-1:0] periph_in_o,
   // Status
   output logic map_write_lock_o,
   output logic cfg_mismatch_rst_o
);
   import rpsel_pkg::*;

   localparam int SYNC_W = RPSEL_PINS + 1;

   // Bus state
   logic busy_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic req_start;
   logic wr_phase;
   logic [4:0] idx;
   logic is_map;
   logic osc_wr;
   logic [15:0] byte_mask;
   logic [15:0] wr_mask;
   logic [15:0] rd_val;

   // Lock state
   rpsel_key_e key_ff;
   logic map_write_lock_ff;

   // Next values
   rpsel_key_e nxt_key;
   logic nxt_lock;

   // Storage
   rpsel_wr_s map_wr;
   logic [15:0] mem_rdata;
   rpsel_map_t map_live;
   logic mismatch;
   logic mismatch_rst_ff;

   // Synchronised pins and fuse
   logic [SYNC_W-1:0] sync_q;
   logic [RPSEL_PINS-1:0] pin_sync;
   logic fuse_sync;

   // Registered pin and peripheral outputs
   logic [RPSEL_PINS-1:0] pin_out_ff;
   logic [RPSEL_PINS-1:0] pin_oe_ff;
   logic [RPSEL_IN_LANES-1:0] periph_in_ff;
   logic [RPSEL_PINS-1:0] nxt_pin_out;
   logic [RPSEL_PINS-1:0] nxt_pin_oe;
   logic [RPSEL_IN_LANES-1:0] nxt_periph_in;

   // Digital input of a pin; analog pins and ground code read low
   function automatic logic pick_pin(input logic [4:0] sel,
                                     input logic [RPSEL_PINS-1:0] pins,
                                     input logic [RPSEL_PINS-1:0] ana);
      pick_pin = 1'b0;
      if (sel < 5'(RPSEL_PINS)) begin
         pick_pin = pins[sel[3:0]] & ~ana[sel[3:0]]; // R14 R19
      end
   endfunction

   // Registers decode only in the low window; upper address bits must be zero
   function automatic logic in_window(input logic [31:0] adr);
      in_window = (adr[31:7] == '0);
   endfunction

   // Fuse rides the pin synchroniser; it only matters after the key sequence
   rpsel_sync2 #(
      .W(SYNC_W)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({one_shot_lock_fuse_i, remap_pin_in_i}),
      .rst_val_i('0),
      .q_o(sync_q)
   );

   assign pin_sync = sync_q[RPSEL_PINS-1:0];
   assign fuse_sync = sync_q[RPSEL_PINS];

   // Bus decode
   assign idx = wb_adr_i[6:2];
   assign req_start = wb_cyc_i & wb_stb_i & ~busy_ff & ~ack_ff;
   assign wr_phase = busy_ff & wb_we_i;
   assign is_map = (idx < 5'(RPSEL_MAP_REGS)) & in_window(wb_adr_i);
   assign osc_wr = wr_phase & (idx == RPSEL_IDX_OSC) & in_window(wb_adr_i) & wb_sel_i[0];
   assign byte_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_mask = byte_mask & rpsel_mask(idx); // R17

   // Locked writes are still acknowledged, only storage is skipped
   always_comb begin
      map_wr.en = wr_phase & is_map & ~map_write_lock_ff; // R3 R4 R18
      map_wr.idx = idx;
      // Read-modify-write keeps the byte lane that sel leaves out
      map_wr.data = (mem_rdata & ~wr_mask) | (wb_dat_i[15:0] & wr_mask); // R1
   end

   rpsel_map_store u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(map_wr),
      .rd_idx_i(idx),
      .rd_data_o(mem_rdata),
      .map_o(map_live),
      .mismatch_o(mismatch)
   );

   // Read data mux; unmapped addresses read zero
   always_comb begin
      rd_val = '0;
      if (is_map) begin
         rd_val = mem_rdata; // R17
      end else if (in_window(wb_adr_i) && idx == RPSEL_IDX_OSC) begin
         rd_val[RPSEL_LOCK_POS] = map_write_lock_ff;
      end else if (in_window(wb_adr_i) && idx == RPSEL_IDX_STAT) begin
         rd_val[RPSEL_STAT_LOCK] = map_write_lock_ff;
         rd_val[RPSEL_STAT_FUSE] = fuse_sync;
         rd_val[RPSEL_STAT_KEY +: 3] = key_ff;
      end
   end

   // Two-cycle access: take, then answer; storage read lands in between
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_ff <= 1'b0;
      end else if (ce_i) begin
         busy_ff <= req_start;
      end
   end

   // Ack is a one-cycle pulse; a request still held during the ack cycle is not taken twice
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else if (ce_i) begin
         ack_ff <= busy_ff;
      end
   end

   // Read data holds until the next answer, so a slow master still sees it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= '0;
      end else if (ce_i && busy_ff) begin
         dat_ff <= {16'h0000, rd_val};
      end
   end

   // Key sequence; any other write in between aborts it
   // Only writes advance it, so reads between the keys do no harm
   always_comb begin
      nxt_key = key_ff;
      case (key_ff)
         RPSEL_KEY_IDLE: begin
            nxt_key = (osc_wr && wb_dat_i[7:0] == RPSEL_KEY1) ?
                      RPSEL_KEY_ONE : RPSEL_KEY_IDLE; // R5
         end
         RPSEL_KEY_ONE: begin
            if (osc_wr && wb_dat_i[7:0] == RPSEL_KEY2) begin
               nxt_key = RPSEL_KEY_TWO; // R5
            end else if (osc_wr && wb_dat_i[7:0] == RPSEL_KEY1) begin
               nxt_key = RPSEL_KEY_ONE;
            end else begin
               nxt_key = RPSEL_KEY_IDLE; // R22
            end
         end
         RPSEL_KEY_TWO: begin
            nxt_key = RPSEL_KEY_IDLE; // R22
         end
         default: begin
            nxt_key = RPSEL_KEY_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_ff <= RPSEL_KEY_IDLE;
      end else if (ce_i && wr_phase) begin
         key_ff <= nxt_key;
      end
   end

   // Lock bit: never self-clears; with the fuse active it only sets
   always_comb begin
      nxt_lock = map_write_lock_ff;
      if (osc_wr && key_ff == RPSEL_KEY_TWO) begin // R5 R22
         if (!(fuse_sync && map_write_lock_ff)) begin // R8 R9
            nxt_lock = wb_dat_i[RPSEL_LOCK_POS]; // R4
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         map_write_lock_ff <= 1'b0; // R11
      end else if (ce_i) begin
         map_write_lock_ff <= nxt_lock; // R6
      end
   end

   // Registered so a glitch on the wide compare cannot reset the device
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mismatch_rst_ff <= 1'b0;
      end else if (ce_i) begin
         mismatch_rst_ff <= mismatch; // R7
      end
   end

   // Input lanes: lane 0 is register 0 bits 12-8, then low and high of the rest
   generate
      for (genvar l = 0; l < RPSEL_IN_LANES; l++) begin : g_in
         localparam int REG = (l + 1) / 2;
         localparam int POS = (l % 2 == 0) ? RPSEL_FLD_HI : RPSEL_FLD_LO;
         // Independent per lane, so many lanes may share one pin
         assign nxt_periph_in[l] = pick_pin(map_live[REG][POS +: 5],
                                            pin_sync, analog_sel_i); // R2 R16 R19
      end
   endgenerate

   // Output fields: pin p in output register p/2, high field for odd p
   generate
      for (genvar p = 0; p < RPSEL_PINS; p++) begin : g_out
         localparam int REG = int'(RPSEL_IDX_OUT_BASE) + p / 2;
         localparam int POS = (p % 2 == 1) ? RPSEL_FLD_HI : RPSEL_FLD_LO;
         logic [4:0] code;
         assign code = map_live[REG][POS +: 5];
         always_comb begin
            // Analog wins over any code; remapping never makes a pin digital
            if (analog_sel_i[p]) begin
               nxt_pin_out[p] = 1'b0; // R14 R21
            end else if (code != RPSEL_OUT_NULL) begin
               nxt_pin_out[p] = periph_out_i[code]; // R2 R20 R21
            end else begin
               nxt_pin_out[p] = port_out_i[p]; // R20
            end
            // Direction stays with the port logic whatever is mapped
            nxt_pin_oe[p] = port_oe_i[p] & ~analog_sel_i[p]; // R12 R14
         end
      end
   endgenerate

   // Peripheral enables live in the peripherals; this block only routes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_in_ff <= '0;
      end else if (ce_i) begin
         periph_in_ff <= nxt_periph_in; // R13
      end
   end

   // Registered pin drive costs one cycle but keeps glitches off the pads
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_ff <= '0;
      end else if (ce_i) begin
         pin_out_ff <= nxt_pin_out;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_oe_ff <= '0;
      end else if (ce_i) begin
         pin_oe_ff <= nxt_pin_oe;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign periph_in_o = periph_in_ff;
   assign remap_pin_out_o = pin_out_ff;
   assign remap_pin_oe_o = pin_oe_ff;
   assign map_write_lock_o = map_write_lock_ff;
   assign cfg_mismatch_rst_o = mismatch_rst_ff;
endmodule

// ==== testbench/rpsel_periph_model.sv ====
module rpsel_periph_model (
   input wire logic clk_i,
   input wire logic [31:0] drive_i,
   output logic [31:0] periph_out_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Outputs move only on the clock, like on-chip peripheral logic
   always @(posedge clk_i) begin
      periph_out_o <= drive_i;
   end
endmodule

// ==== testbench/rpsel_top_asserts.sv ====
module rpsel_top_asserts
   import rpsel_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic one_shot_lock_fuse_i,
   input wire logic [RPSEL_PINS-1:0] analog_sel_i,
   input wire logic [RPSEL_PINS-1:0] port_oe_i,
   input wire logic [RPSEL_PINS-1:0] remap_pin_out_o,
   input wire logic [RPSEL_PINS-1:0] remap_pin_oe_o,
   input wire logic map_write_lock_o,
   input wire logic cfg_mismatch_rst_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_ack_lat;
      wb_cyc_i && wb_stb_i && !$past(wb_cyc_i) && !$past(rst_i) |-> ##2 wb_ack_o;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_oe; !$past(rst_i) |-> remap_pin_oe_o == $past(port_oe_i & ~analog_sel_i); endproperty
   a_oe: assert property (p_oe) else $error("pin direction altered");
   property p_ana; !$past(rst_i) |-> ($past(analog_sel_i) & remap_pin_out_o) == '0; endproperty
   a_ana: assert property (p_ana) else $error("analog pin driven");
   property p_lock_src;
      !$past(rst_i) && $changed(map_write_lock_o)
         |-> wb_ack_o && $past(wb_we_i) && $past(wb_adr_i[6:2]) == RPSEL_IDX_OSC;
   endproperty
   a_lock_src: assert property (p_lock_src) else $error("lock moved alone");
   property p_oneway;
      one_shot_lock_fuse_i && $past(one_shot_lock_fuse_i, 4) && $past(map_write_lock_o)
         && !$past(rst_i) |-> map_write_lock_o;
   endproperty
   a_oneway: assert property (p_oneway) else $error("lock cleared under fuse");
   property p_no_mism; !cfg_mismatch_rst_o; endproperty
   a_no_mism: assert property (p_no_mism) else $error("spurious mismatch reset");
   property p_reg0_bits;
      wb_ack_o && !wb_we_i && wb_adr_i == 32'h0000_0000
         |-> wb_dat_o[15:13] == 3'h0 && wb_dat_o[7:0] == 8'h00;
   endproperty
   a_reg0_bits: assert property (p_reg0_bits) else $error("reg0 spare bits set");
   property p_lock_rst; $fell(rst_i) |-> !map_write_lock_o; endproperty
   a_lock_rst: assert property (p_lock_rst) else $error("lock set after reset");
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_lock: cover property ($rose(map_write_lock_o));
   c_unlock: cover property ($fell(map_write_lock_o));
endmodule

// ==== testbench/tb_remappable_pin_select_with_lock.sv ====
module tb_remappable_pin_select_with_lock;
   timeunit 1ns;
   timeprecision 1ps;
   import rpsel_pkg::*;
   logic clk_i, rst_i, ce, cyc, stb, we, fuse, ack, lock, mism;
   logic [31:0] adr, wdat, rdat, q, drive, pout;
   logic [3:0] sel;
   logic [15:0] pins, ana, port_out, port_oe, pin_out, pin_oe;
   logic [16:0] pin_lanes;
   int err_total = 0;
   int checks_done = 0;
   rpsel_periph_model i_far (.clk_i(clk_i), .drive_i(drive), .periph_out_o(pout));
   rpsel_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .one_shot_lock_fuse_i(fuse),
      .remap_pin_in_i(pins), .analog_sel_i(ana), .port_out_i(port_out),
      .port_oe_i(port_oe), .remap_pin_out_o(pin_out), .remap_pin_oe_o(pin_oe),
      .periph_out_i(pout), .periph_in_o(pin_lanes), .map_write_lock_o(lock),
      .cfg_mismatch_rst_o(mism));
   initial begin
      clk_i = 0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [31:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      // Key writes touch the low byte only
      sel <= (a == 32'h0000_0060) ? 4'h1 : 4'h3;
      wdat <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("wb_ack", 1, ack);
   endtask
   task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
      wb(0, a, 16'h0000);
      chk(nm, e, q);
   endtask
   task automatic keyseq(input logic [15:0] v);
      wb(1, 32'h0000_0060, 16'h0046);
      wb(1, 32'h0000_0060, 16'h0057);
      wb(1, 32'h0000_0060, v);
   endtask
   task automatic pin_chk(input logic [15:0] p, input logic [2:0] e, input string nm);
      @(posedge clk_i);
      pins <= p;
      repeat (4) @(posedge clk_i);
      chk(nm, e, pin_lanes[2:0]);
   endtask
   task automatic out_chk(input logic [31:0] d, input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_i);
      drive <= d;
      ana <= a;
      repeat (3) @(posedge clk_i);
      chk("pins oe out", e, {pin_oe[3:0], pin_out[3:0]});
   endtask
   task automatic t_reset;
      rdchk("reg0", 32'h0000_0000, 0);
      rdchk("reg9", 32'h0000_0024, 0);
      rdchk("status", 32'h0000_0064, 32'h0000_0006);
      $display("test reset done");
   endtask
   task automatic t_fields;
      logic [15:0] v;
      for (int r = 0; r < 17; r++) wb(1, r * 4, 16'hffff ^ 16'(r * 257));
      for (int r = 0; r < 17; r++) begin
         v = 16'hffff ^ 16'(r * 257);
         rdchk("map reg", r * 4, v & (r == 0 ? RPSEL_REG0_MASK : RPSEL_MAP_MASK));
      end
      wb(1, 32'h0000_0050, 16'hffff);
      rdchk("unmapped", 32'h0000_0050, 0);
      chk("mismatch rst", 0, mism);
      $display("test fields done");
   endtask
   task automatic t_input;
      wb(1, 32'h0000_0000, 16'h0500);
      wb(1, 32'h0000_0004, 16'h0505);
      pin_chk(16'h0020, 3'b111, "pin5 high");
      pin_chk(16'hffdf, 3'b000, "pin5 low");
      wb(1, 32'h0000_0000, 16'h1f00);
      pin_chk(16'hffff, 3'b110, "grounded");
      wb(1, 32'h0000_0000, 16'h0f00);
      pin_chk(16'h8000, 3'b001, "pin15");
      @(posedge clk_i);
      ce <= 1'b0;
      pins <= 16'h0020;
      repeat (4) @(posedge clk_i);
      chk("frozen lanes", 3'b001, pin_lanes[2:0]);
      ce <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("thawed lanes", 3'b110, pin_lanes[2:0]);
      $display("test input done");
   endtask
   task automatic t_output;
      wb(1, 32'h0000_0024, 16'h0403);
      wb(1, 32'h0000_0028, 16'h0003);
      out_chk(32'h0000_0008, 16'h0000, 8'hfd);
      out_chk(32'h0000_0010, 16'h0000, 8'hfa);
      out_chk(32'h0000_0008, 16'h0001, 8'hec);
      $display("test output done");
   endtask
   task automatic t_lock;
      wb(1, 32'h0000_0060, 16'h0040);
      chk("lock no keys", 0, lock);
      keyseq(16'h0040);
      chk("lock set", 1, lock);
      wb(1, 32'h0000_0000, 16'h0a00);
      rdchk("locked reg0", 32'h0000_0000, 32'h0000_0f00);
      wb(1, 32'h0000_0060, 16'h0046);
      wb(1, 32'h0000_0004, 16'h0000);
      wb(1, 32'h0000_0060, 16'h0057);
      wb(1, 32'h0000_0060, 16'h0000);
      chk("aborted", 1, lock);
      keyseq(16'h0000);
      chk("fuse holds", 1, lock);
      @(posedge clk_i);
      fuse <= 1'b0;
      repeat (4) @(posedge clk_i);
      keyseq(16'h0000);
      chk("unlocked", 0, lock);
      wb(1, 32'h0000_0000, 16'h0300);
      wb(1, 32'h0000_0004, 16'h0102);
      rdchk("reg0 after", 32'h0000_0000, 32'h0000_0300);
      rdchk("reg1 after", 32'h0000_0004, 32'h0000_0102);
      keyseq(16'h0040);
      keyseq(16'h0000);
      chk("second session", 0, lock);
      $display("test lock done");
   endtask
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, sel, adr, wdat} = '0;
      {pins, ana, drive} = '0;
      fuse = 1'b1;
      ce = 1'b1;
      port_out = 16'h000f;
      port_oe = 16'h000f;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_fields();
      t_input();
      t_output();
      t_lock();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      tally_and_finish();
   end
endmodule
bind rpsel_top rpsel_top_asserts i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .one_shot_lock_fuse_i, .analog_sel_i, .port_oe_i,
   .remap_pin_out_o, .remap_pin_oe_o, .map_write_lock_o, .cfg_mismatch_rst_o);
